// >>> csq_pkg.sv
// shared constants and types for the continuous segment queue
package csq_pkg;
  localparam int         DEPTH          = 8;
  localparam logic [3:0] CNT_FULL       = 4'h8;
  localparam logic [3:0] CNT_HALF       = 4'h4;
  localparam logic [3:0] CNT_ONE        = 4'h1;
  localparam logic [3:0] CNT_EMPTY      = 4'h0;
  localparam logic [7:0] OFS_MAIN_STAT  = 8'h00;
  localparam logic [7:0] OFS_SEC_ERR    = 8'h04;
  localparam logic [7:0] OFS_MODE_PARAM = 8'h08;
  localparam logic [7:0] OFS_SEG_DATA   = 8'h0c;
  localparam logic [7:0] OFS_COMMAND    = 8'h10;
  localparam logic [7:0] CMD_MODE_SET   = 8'h2a;
  localparam logic [7:0] CMD_STOP       = 8'h26;
  localparam logic [7:0] CMD_IRQ_CLR    = 8'h6f;
  localparam logic [7:0] CMD_HOLD       = 8'h77;
  localparam logic [7:0] CMD_HOLD_REL   = 8'h78;
  localparam logic [7:0] CMD_ERR_CLR    = 8'h79;
  localparam int         MODE_INT_HALF  = 14;
  localparam int         MODE_INT_ONE   = 15;
  localparam int         ST_CNT_LSB     = 12;
  localparam int         ST_NEXT        = 11;
  localparam int         ST_ERR_LSB     = 4;
  localparam int         SEC_LATE       = 7;
  localparam logic [15:0] MODE_RST      = 16'h0000;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_RUN  = 3'b010,
    RS_LATE = 3'b100
  } csq_run_e;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [31:0] data;
  } csq_seg_s;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } csq_wr_s;

  // interpolation driving commands sit in the 6xh group
  function automatic logic csq_is_interp(input logic [7:0] c);
    return (c[7:4] == 4'h6) && (c != CMD_IRQ_CLR);
  endfunction : csq_is_interp
endpackage : csq_pkg

// >>> csq_seg_store.sv
// eight stage segment pre-buffer with count, push, pop and flush
module csq_seg_store
  import csq_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     push,
  input  csq_seg_s      push_seg,
  input  wire logic     pop,
  input  wire logic     flush,
  output logic [3:0]    count,
  output csq_seg_s      head
);
  typedef struct packed {
    csq_seg_s [DEPTH-1:0] mem;
    logic [2:0]           wp;
    logic [2:0]           rp;
    logic [3:0]           cnt;
  } csq_store_s;

  csq_store_s s_reg;
  csq_store_s s_next;

  always_comb begin
    s_next = s_reg;
    if (flush) begin
      s_next.rp  = s_reg.wp; // queued stages are simply abandoned
      s_next.cnt = CNT_EMPTY;
    end else begin
      if (push && s_reg.cnt != CNT_FULL) begin
        s_next.mem[s_reg.wp] = push_seg;
        s_next.wp = s_reg.wp + 3'h1;
      end
      if (pop && s_reg.cnt != CNT_EMPTY) begin
        s_next.rp = s_reg.rp + 3'h1;
      end
      s_next.cnt = s_reg.cnt
                 + {3'h0, push && s_reg.cnt != CNT_FULL}
                 - {3'h0, pop && s_reg.cnt != CNT_EMPTY};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.cnt;
  assign head  = s_reg.mem[s_reg.rp];
endmodule : csq_seg_store

// >>> csq_axil_port.sv
// axi4-lite slave front end: one write and one read in flight
module csq_axil_port
  import csq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit,
  output csq_wr_s          wr
);
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    csq_wr_s     wr;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } csq_axil_s;

  csq_axil_s s_reg;
  csq_axil_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.wr.en = 1'b0;
    if (awvalid && s_reg.awready) begin
      s_next.aw_got  = 1'b1;
      s_next.wr.addr = awaddr;
    end
    if (wvalid && s_reg.wready) begin
      s_next.w_got   = 1'b1;
      s_next.wr.data = wdata;
      s_next.wr.strb = wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.wr.en  = 1'b1;
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    // address and data wait for the response to drain first
    s_next.awready = !s_next.aw_got && !s_next.bvalid && !s_next.wr.en;
    s_next.wready  = !s_next.w_got && !s_next.bvalid && !s_next.wr.en;
    if (arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_data;
      s_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    s_next.arready = !s_next.rvalid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.awready;
  assign wready  = s_reg.wready;
  assign bvalid  = s_reg.bvalid;
  assign bresp   = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid  = s_reg.rvalid;
  assign rresp   = s_reg.rresp;
  assign rdata   = s_reg.rdata;
  assign wr      = s_reg.wr;
endmodule : csq_axil_port

// >>> csq_top.sv
// continuous interpolation segment queue with axi4-lite registers
module csq_top
  import csq_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic [3:0]  LIMIT_ERR,
  input  wire logic        SEG_DONE,
  input  wire logic        LAST_PULSE_DONE,
  output logic             SEG_RUN,
  output logic [7:0]       SEG_CMD,
  output logic [31:0]      SEG_WORD,
  output logic [3:0]       AXIS_SEL,
  output logic             BUFFER_IRQ_N_O,
  output logic             BUFFER_IRQ_N_OE
);
  typedef struct packed {
    csq_run_e    st;
    logic [15:0] param;
    logic [15:0] mode;
    logic [31:0] seg_data;
    logic        hold;
    logic [3:0]  axis_err;
    logic        late_err;
    logic        irq;
    logic        irq_n;
    logic        seg_run;
    csq_seg_s    seg;
  } csq_top_s;

  csq_top_s   s_reg;
  csq_top_s   s_next;
  csq_wr_s    wr;
  csq_seg_s   head;
  csq_seg_s   new_seg;
  logic [3:0] cnt;
  logic [3:0] cnt_after;
  logic       push;
  logic       pop;
  logic       flush;
  logic       cmd_wr;
  logic [7:0] code;
  logic       err_any;
  logic       running;
  logic       writable;
  logic [3:0] lim;
  logic [31:0] rd_data;

  function automatic logic hit(input logic [7:0] a);
    return a == OFS_MAIN_STAT || a == OFS_SEC_ERR ||
           a == OFS_MODE_PARAM || a == OFS_SEG_DATA ||
           a == OFS_COMMAND;
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  csq_axil_port u_port (
    .clk     (CLK),
    .rst     (SYS_RST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .rd_data (rd_data),
    .rd_hit  (hit(S_AXI_ARADDR)),
    .wr_hit  (hit(wr.addr)),
    .wr      (wr)
  );

  csq_seg_store u_store (
    .clk      (CLK),
    .rst      (SYS_RST),
    .push     (push),
    .push_seg (new_seg),
    .pop      (pop),
    .flush    (flush),
    .count    (cnt),
    .head     (head)
  );

  assign running  = s_reg.st != RS_IDLE;
  assign err_any  = (|s_reg.axis_err) || s_reg.late_err;
  assign writable = running && cnt != CNT_EMPTY && cnt != CNT_FULL;
  assign cmd_wr   = wr.en && wr.addr == OFS_COMMAND && wr.strb[0];
  assign code     = wr.data[7:0];
  assign lim      = LIMIT_ERR & s_reg.mode[3:0];
  assign new_seg  = '{cmd: code, data: s_reg.seg_data};

  always_comb begin
    rd_data = 32'h0000_0000;
    case (S_AXI_ARADDR)
      OFS_MAIN_STAT: begin
        rd_data[ST_CNT_LSB +: 4] = cnt;
        rd_data[ST_NEXT]         = writable;
        rd_data[ST_ERR_LSB +: 4] = s_reg.axis_err;
        rd_data[3:0] = running ? s_reg.mode[3:0] : 4'h0;
      end
      OFS_SEC_ERR:    rd_data[SEC_LATE] = s_reg.late_err;
      OFS_MODE_PARAM: rd_data[15:0] = s_reg.param;
      OFS_SEG_DATA:   rd_data = s_reg.seg_data;
      default:        rd_data = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    push   = 1'b0;
    flush  = 1'b0;
    pop    = running && SEG_DONE;
    if (wr.en && wr.addr == OFS_MODE_PARAM) begin
      s_next.param = 16'(merge({16'h0, s_reg.param}, wr.data, wr.strb));
    end
    if (wr.en && wr.addr == OFS_SEG_DATA) begin
      s_next.seg_data = merge(s_reg.seg_data, wr.data, wr.strb);
    end
    if (cmd_wr) begin
      if (code == CMD_MODE_SET && !running) begin
        s_next.mode = s_reg.param;
      end else if (code == CMD_HOLD) begin
        s_next.hold = 1'b1;
      end else if (code == CMD_HOLD_REL) begin
        s_next.hold = 1'b0;
        if (cnt != CNT_EMPTY && !err_any && !running) begin
          s_next.st = RS_RUN;
        end
      end else if (code == CMD_IRQ_CLR) begin
        s_next.irq = 1'b0;
      end else if (code == CMD_ERR_CLR) begin
        s_next.axis_err = 4'h0;
        s_next.late_err = 1'b0;
      end else if (code == CMD_STOP) begin
        flush = 1'b1;
      end else if (csq_is_interp(code)) begin
        if (s_reg.st == RS_LATE) begin
          s_next.late_err = 1'b1;
          flush = 1'b1;
        end else if (!err_any && cnt != CNT_FULL) begin
          push = 1'b1;
          s_next.irq = 1'b0;
          if (!s_reg.hold && !running) begin
            s_next.st = RS_RUN;
          end
        end
      end
    end
    cnt_after = cnt + {3'h0, push} - {3'h0, pop};
    if (pop) begin
      if (cnt_after == CNT_EMPTY) begin
        s_next.st  = RS_IDLE;
        s_next.irq = 1'b0;
      end else begin
        s_next.st = RS_RUN;
        if (!push && cnt == CNT_HALF && s_reg.mode[MODE_INT_HALF]) begin
          s_next.irq = 1'b1;
        end
        if (!push && cnt == CNT_FULL && s_reg.mode[MODE_INT_ONE]) begin
          s_next.irq = 1'b1;
        end
      end
    end else if (s_reg.st == RS_RUN && LAST_PULSE_DONE &&
                 cnt == CNT_ONE && !push) begin
      s_next.st = RS_LATE; // from here a new command comes too late
    end
    if (running && (|lim)) begin
      s_next.axis_err = s_reg.axis_err | lim;
      flush = 1'b1;
    end
    if (flush) begin
      push       = 1'b0;
      pop        = 1'b0;
      s_next.st  = RS_IDLE;
      s_next.irq = 1'b0;
    end
    // run and segment outputs lag the queue by one cycle, irq_n flops with irq, so each comes from a flop
    s_next.irq_n   = !s_next.irq;
    s_next.seg_run = running;
    s_next.seg     = head;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_reg       <= '0;
      s_reg.st    <= RS_IDLE;
      s_reg.mode  <= MODE_RST;
      s_reg.param <= MODE_RST;
      s_reg.irq_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign SEG_RUN         = s_reg.seg_run;
  assign SEG_CMD         = s_reg.seg.cmd;
  assign SEG_WORD        = s_reg.seg.data;
  assign AXIS_SEL        = s_reg.mode[3:0];
  assign BUFFER_IRQ_N_O  = s_reg.irq_n;
  assign BUFFER_IRQ_N_OE = s_reg.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  logic cmd_ok;
  assign cmd_ok = cmd_wr && csq_is_interp(code);

  sequence s_drop(logic [3:0] from);
    pop && !push && !flush && cnt == from;
  endsequence

  property p_full_ignore;
    cmd_ok && cnt == CNT_FULL && !SEG_DONE && !(|lim) |=> cnt == CNT_FULL;
  endproperty
  a_full_ignore: assert property (p_full_ignore)
    else $error("command while full changed the count");

  property p_count_up;
    push && !pop |=> cnt == $past(cnt) + 4'h1;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("stack count did not step up");

  property p_irq_half;
    s_drop(CNT_HALF) and s_reg.mode[MODE_INT_HALF]
      |=> !BUFFER_IRQ_N_O && BUFFER_IRQ_N_OE;
  endproperty
  a_irq_half: assert property (p_irq_half)
    else $error("no interrupt on count 4 to 3");

  property p_irq_one;
    s_drop(CNT_FULL) and s_reg.mode[MODE_INT_ONE]
      |=> cnt == 4'h7 && BUFFER_IRQ_N_OE;
  endproperty
  a_irq_one: assert property (p_irq_one)
    else $error("no interrupt on count 8 to 7");

  property p_irq_release;
    BUFFER_IRQ_N_OE && push |=> !BUFFER_IRQ_N_OE && BUFFER_IRQ_N_O;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("driving command did not release interrupt");

  property p_irq_clear;
    cmd_wr && code == CMD_IRQ_CLR && !pop |=> !BUFFER_IRQ_N_OE;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("clear command did not release interrupt");

  property p_limit;
    running && (|lim) |=> cnt == CNT_EMPTY && !running
      && (s_reg.axis_err & $past(lim)) == $past(lim);
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit error did not empty the queue");

  property p_late;
    s_reg.st == RS_LATE && cmd_ok |=> s_reg.late_err
      && cnt == CNT_EMPTY && !running;
  endproperty
  a_late: assert property (p_late)
    else $error("late command not flagged");

  property p_stop;
    cmd_wr && code == CMD_STOP |=> cnt == CNT_EMPTY ##1 !SEG_RUN;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not discard the queue");

  property p_err_block;
    err_any && cmd_ok |=> cnt == $past(cnt);
  endproperty
  a_err_block: assert property (p_err_block)
    else $error("driving accepted while error stands");

  property p_hold;
    s_reg.hold && !running && cmd_ok && !err_any |=> !running;
  endproperty
  a_hold: assert property (p_hold)
    else $error("driving started while holding");

  property p_release;
    cmd_wr && code == CMD_HOLD_REL && cnt != CNT_EMPTY && !err_any
      && !(|lim) && !SEG_DONE |=> running ##1 SEG_RUN;
  endproperty
  a_release: assert property (p_release)
    else $error("release did not start driving");
endmodule : csq_top

// >>> csq_seg_engine.sv
// segment engine stand-in: ends each running segment after a fixed time
module csq_seg_engine #(
  parameter int LEN  = 40,
  parameter int LEAD = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic go,
  output logic      last_pulse,
  output logic      seg_done
);
  int cnt;

  // last pulse comes LEAD cycles before the finish (16 here); a command written after it is late when only the running segment is queued
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      last_pulse <= 1'b0;
      seg_done <= 1'b0;
    end else begin
      last_pulse <= run && go && (cnt == LEN - LEAD);
      seg_done <= run && go && (cnt == LEN);
      if (!run || !go || cnt == LEN) begin
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : csq_seg_engine

// >>> csq_top_test.sv
// self-checking bench for the continuous segment queue
module csq_top_test import csq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, limit_err, axis_sel;
  logic        awvalid, wvalid, bready, arvalid, rready, eng_go;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic        seg_run, irq_o, irq_oe, eng_last, eng_done;
  logic [7:0]  seg_cmd;
  logic [31:0] seg_word;
  logic [31:0] seed = 32'h31095bdb;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  csq_seg_s    exp_q[$];
  // the interrupt line is open drain with a pull-up on the board
  wire         irq_pin = irq_oe ? irq_o : 1'b1;

  always #2.5 clk = ~clk;

  csq_top dut (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .LIMIT_ERR(limit_err), .SEG_DONE(eng_done),
    .LAST_PULSE_DONE(eng_last), .SEG_RUN(seg_run), .SEG_CMD(seg_cmd),
    .SEG_WORD(seg_word), .AXIS_SEL(axis_sel), .BUFFER_IRQ_N_O(irq_o),
    .BUFFER_IRQ_N_OE(irq_oe));

  csq_seg_engine #(.LEN(40), .LEAD(16)) engine (.clk(clk), .rst(rst),
    .run(seg_run), .go(eng_go), .last_pulse(eng_last), .seg_done(eng_done));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic logic exp_next(input logic [3:0] c, input logic drv);
    return drv && (c >= 4'h1) && (c <= 4'h7);
  endfunction : exp_next

  task automatic end_of_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // let the effect edge settle before anyone looks at the outputs
    @(negedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd

  task automatic cmd(input logic [7:0] c);
    axi_wr(OFS_COMMAND, {24'h0, c});
  endtask : cmd

  // data word first, driving command last; only two-axis line and arc codes
  task automatic push(input logic take);
    logic [7:0]  code;
    logic [31:0] data;
    seed = xs(seed);
    code = (seed[1:0] == 2'h0) ? 8'h61 : {7'h32, seed[0]};
    data = xs(seed);
    seed = data;
    axi_wr(OFS_SEG_DATA, data);
    cmd(code);
    if (take) exp_q.push_back('{cmd: code, data: data});
  endtask : push

  task automatic stat(input logic [3:0] c, input logic drv,
                      input logic [3:0] e);
    axi_rd(OFS_MAIN_STAT);
    chk(rd[15:11], {c, exp_next(c, drv)});
    chk(rd[7:4], e);
  endtask : stat

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  // the segment that finishes must be the oldest one queued
  always @(negedge clk) begin
    if (!rst && eng_done && seg_run && exp_q.size() > 0) begin
      chk(seg_cmd, exp_q[0].cmd);
      chk(seg_word, exp_q[0].data);
      void'(exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, eng_go} = '0;
    {awaddr, araddr, wdata, wstrb, limit_err} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    eng_go <= 1'b1;
    stat(4'h0, 1'b0, 4'h0);
    chk(irq_oe, 1'b0);
    axi_rd(OFS_SEC_ERR);
    chk(rd[SEC_LATE], 1'b0);
    axi_wr(8'h40, 32'h5a);
    chk(resp, RESP_SLVERR);
    axi_rd(8'h40);
    chk(resp, RESP_SLVERR);
    axi_wr(OFS_MODE_PARAM, 32'h8003);
    axi_rd(OFS_MODE_PARAM);
    chk(rd[15:0], 16'h8003);
    cmd(CMD_MODE_SET);
    chk(axis_sel, 4'h3);
    cmd(CMD_HOLD);
    for (int i = 0; i < 8; i++) begin
      push(1'b1);
      stat(4'(i + 1), 1'b0, 4'h0);
    end
    chk(seg_run, 1'b0);
    push(1'b0);
    stat(4'h8, 1'b0, 4'h0);
    cmd(CMD_HOLD_REL);
    settle(2);
    chk(seg_run, 1'b1);
    stat(4'h8, 1'b1, 4'h0);
    @(negedge clk iff eng_done);
    settle(3);
    chk(irq_pin, 1'b0);
    stat(4'h7, 1'b1, 4'h0);
    push(1'b1);
    chk(irq_oe, 1'b0);
    @(negedge clk iff eng_done);
    settle(3);
    chk(irq_pin, 1'b0);
    cmd(CMD_IRQ_CLR);
    chk(irq_oe, 1'b0);
    wait (exp_q.size() == 0);
    settle(3);
    chk(seg_run, 1'b0);
    chk(irq_oe, 1'b0);
    stat(4'h0, 1'b0, 4'h0);
    // second run: half-empty interrupt only
    axi_wr(OFS_MODE_PARAM, 32'h4003);
    cmd(CMD_MODE_SET);
    cmd(CMD_HOLD);
    repeat (4) push(1'b1);
    cmd(CMD_HOLD_REL);
    stat(4'h4, 1'b1, 4'h0);
    chk(irq_pin, 1'b1);
    @(negedge clk iff eng_done);
    settle(3);
    chk(irq_pin, 1'b0);
    wait (exp_q.size() == 0);
    settle(3);
    chk(irq_oe, 1'b0);
    // a segment written in time chains on, one written late is refused
    push(1'b1);
    push(1'b1);
    @(negedge clk iff eng_done);
    axi_rd(OFS_SEC_ERR);
    chk(rd[SEC_LATE], 1'b0);
    @(negedge clk iff eng_last);
    push(1'b0);
    exp_q.delete();
    axi_rd(OFS_SEC_ERR);
    chk(rd[SEC_LATE], 1'b1);
    chk(seg_run, 1'b0);
    stat(4'h0, 1'b0, 4'h0);
    push(1'b0);
    stat(4'h0, 1'b0, 4'h0);
    cmd(CMD_ERR_CLR);
    axi_rd(OFS_SEC_ERR);
    chk(rd[SEC_LATE], 1'b0);
    // limit fault on the Y axis in mid-run
    cmd(CMD_HOLD);
    repeat (3) push(1'b1);
    cmd(CMD_HOLD_REL);
    @(posedge clk);
    // z is not a selected axis, so only the y fault may count
    limit_err <= 4'h6;
    @(posedge clk);
    limit_err <= 4'h0;
    exp_q.delete();
    settle(3);
    chk(seg_run, 1'b0);
    stat(4'h0, 1'b0, 4'h2);
    push(1'b0);
    stat(4'h0, 1'b0, 4'h2);
    cmd(CMD_ERR_CLR);
    stat(4'h0, 1'b0, 4'h0);
    // stop command throws the whole queue away
    cmd(CMD_HOLD);
    repeat (3) push(1'b1);
    cmd(CMD_HOLD_REL);
    cmd(CMD_STOP);
    exp_q.delete();
    settle(2);
    chk(seg_run, 1'b0);
    stat(4'h0, 1'b0, 4'h0);
    end_of_test();
  end
endmodule : csq_top_test
